// [pin_meas.sv]
// pin_meas: per-pin input measurement unit with an avalon-mm register port
// assumes: pin_a and pin_b are asynchronous pins; master follows avalon-mm waitrequest rules
`timescale 1ns/10ps

module pin_meas (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic pin_a,
  input wire logic pin_b,
  output logic done_flag
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v >= pin_meas_pkg::RESULT_MAX) ? pin_meas_pkg::RESULT_MAX : v + 32'h00000001;
  endfunction

  function automatic logic [31:0] delta(input logic up, input logic dn);
    delta = {{31{dn & ~up}}, up ^ dn};
  endfunction

  function automatic logic [31:0] reg_read(input logic [4:0] a, input pin_meas_pkg::meas_state_t s);
    reg_read = 32'h00000000;
    case (a)
      pin_meas_pkg::OFF_CTRL: reg_read[pin_meas_pkg::CTRL_RUN_BIT] = s.run;
      pin_meas_pkg::OFF_MODE: begin
        reg_read[4:0] = s.mode;
        reg_read[pin_meas_pkg::MODE_B_SAME_BIT] = s.b_same;
      end
      pin_meas_pkg::OFF_PERIOD: reg_read = s.period_x;
      pin_meas_pkg::OFF_EDGE: reg_read[1:0] = s.edge_y;
      pin_meas_pkg::OFF_RESULT_ACK: reg_read = s.result;
      pin_meas_pkg::OFF_RESULT_QUIET: reg_read = s.result;
      pin_meas_pkg::OFF_STATUS: begin
        reg_read[pin_meas_pkg::STAT_FLAG_BIT] = s.flag;
        reg_read[pin_meas_pkg::STAT_CFLAG_BIT] = s.cflag;
        reg_read[pin_meas_pkg::STAT_RUN_BIT] = s.run;
      end
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  pin_meas_pkg::meas_state_t s_r;
  pin_meas_pkg::meas_state_t s_nxt;

  logic b_now;
  logic a_ev;
  logic b_ev;
  logic up;
  logic dn;
  logic [31:0] inc;
  logic take;
  logic clear;
  logic done;
  logic is_count;
  logic is_timing;

  // ************************************************************
  // combinational next state
  // ************************************************************
  always_comb begin
    logic per_end;
    logic fin;
    logic [31:0] acc_p;
    logic [31:0] hits_p;
    per_end = 1'b0;
    fin = 1'b0;
    acc_p = 32'h00000000;
    hits_p = 32'h00000000;
    s_nxt = s_r;

    // input sampling and edge compare
    s_nxt.a_s1 = pin_a;
    s_nxt.a_s2 = s_r.a_s1;
    s_nxt.a_prev = s_r.a_s2;
    s_nxt.b_s1 = pin_b;
    s_nxt.b_s2 = s_r.b_s1;
    b_now = s_r.b_same ? s_r.a_s2 : s_r.b_s2;
    s_nxt.b_prev = b_now;
    a_ev = s_r.edge_y[pin_meas_pkg::EDGE_A_ANY_BIT] ? (s_r.a_s2 ^ s_r.a_prev)
                                                    : (s_r.a_s2 & ~s_r.a_prev);
    b_ev = s_r.edge_y[pin_meas_pkg::EDGE_B_ANY_BIT] ? (b_now ^ s_r.b_prev) : (b_now & ~s_r.b_prev);

    // increment of the counting modes
    case (s_r.mode)
      pin_meas_pkg::M_CNT_HIGH: begin
        up = s_r.a_s2;
        dn = 1'b0;
      end
      pin_meas_pkg::M_CNT_EDGE: begin
        up = s_r.a_s2 & ~s_r.a_prev;
        dn = 1'b0;
      end
      pin_meas_pkg::M_CMP_HIGH: begin
        up = s_r.a_s2;
        dn = b_now;
      end
      pin_meas_pkg::M_CMP_EDGE: begin
        up = s_r.a_s2 & ~s_r.a_prev;
        dn = b_now & ~s_r.b_prev;
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    inc = delta(up, dn);
    is_count = (s_r.mode >= pin_meas_pkg::M_CNT_HIGH) && (s_r.mode <= pin_meas_pkg::M_CMP_EDGE);
    is_timing = (s_r.mode >= pin_meas_pkg::M_TIME_STATE) && (s_r.mode <= pin_meas_pkg::M_MIN_PERIODS);

    // avalon slave: answer one cycle after the request is seen
    take = (read | write) & ~s_r.waitreq;
    s_nxt.waitreq = 1'b1;
    if ((read | write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = reg_read(address, s_r);
    end
    clear = take && ((write && (address == pin_meas_pkg::OFF_ACK || address == pin_meas_pkg::OFF_MODE
                     || address == pin_meas_pkg::OFF_PERIOD || address == pin_meas_pkg::OFF_EDGE))
                     || (read && address == pin_meas_pkg::OFF_RESULT_ACK));
    if (take && write) begin
      case (address)
        pin_meas_pkg::OFF_CTRL: s_nxt.run = writedata[pin_meas_pkg::CTRL_RUN_BIT];
        pin_meas_pkg::OFF_MODE: begin
          s_nxt.mode = writedata[4:0];
          s_nxt.b_same = writedata[pin_meas_pkg::MODE_B_SAME_BIT];
        end
        pin_meas_pkg::OFF_PERIOD: s_nxt.period_x = writedata;
        pin_meas_pkg::OFF_EDGE: s_nxt.edge_y = writedata[1:0];
        default: s_nxt.run = s_r.run;
      endcase
    end

    // measurement engine
    done = 1'b0;
    if (!s_r.run) begin
      s_nxt.acc = 32'h00000000;
      s_nxt.cnt = 32'h00000000;
      s_nxt.hits = 32'h00000000;
      s_nxt.in_per = 1'b0;
      if (is_count) begin
        s_nxt.result = inc;
      end else if (s_r.mode <= pin_meas_pkg::M_TIME_XHIGHS && is_timing) begin
        s_nxt.result = pin_meas_pkg::TIMING_RESET_RESULT;
      end else if (is_timing) begin
        s_nxt.result = pin_meas_pkg::PERIOD_RESET_RESULT;
      end
    end else begin
      case (s_r.mode)
        pin_meas_pkg::M_CNT_HIGH, pin_meas_pkg::M_CNT_EDGE, pin_meas_pkg::M_CMP_HIGH,
        pin_meas_pkg::M_CMP_EDGE: begin
          if (s_r.period_x == 32'h00000000) begin
            s_nxt.acc = s_r.acc + inc;
            s_nxt.result = s_r.acc + inc;
            s_nxt.cnt = 32'h00000000;
          end else if (s_r.cnt >= s_r.period_x - 32'h00000001) begin
            s_nxt.result = s_r.acc;
            s_nxt.acc = inc;
            s_nxt.cnt = 32'h00000000;
            done = 1'b1;
          end else begin
            s_nxt.acc = s_r.acc + inc;
            s_nxt.cnt = s_r.cnt + 32'h00000001;
          end
        end
        pin_meas_pkg::M_TIME_STATE: begin
          if (s_r.a_s2 != s_r.a_prev) begin
            s_nxt.cflag = s_r.a_prev;
            s_nxt.result = s_r.acc;
            s_nxt.acc = 32'h00000001;
            done = 1'b1;
          end else begin
            s_nxt.acc = sat_inc(s_r.acc);
          end
        end
        pin_meas_pkg::M_TIME_HIGH: begin
          if (s_r.a_prev && !s_r.a_s2) begin
            s_nxt.result = s_r.acc;
            s_nxt.acc = 32'h00000000;
            done = 1'b1;
          end else if (s_r.a_s2) begin
            s_nxt.acc = sat_inc(s_r.acc);
          end
        end
        pin_meas_pkg::M_TIME_XHIGHS: begin
          acc_p = sat_inc(s_r.acc);
          hits_p = s_r.hits + {31'h00000000, s_r.a_s2};
          if (hits_p >= s_r.period_x) begin
            s_nxt.result = acc_p;
            s_nxt.acc = 32'h00000000;
            s_nxt.hits = 32'h00000000;
            done = 1'b1;
          end else begin
            s_nxt.acc = acc_p;
            s_nxt.hits = hits_p;
          end
        end
        pin_meas_pkg::M_NPER_TIME, pin_meas_pkg::M_NPER_STATES, pin_meas_pkg::M_MIN_TIME,
        pin_meas_pkg::M_MIN_STATES, pin_meas_pkg::M_MIN_PERIODS: begin
          acc_p = s_r.acc;
          hits_p = s_r.hits;
          if (s_r.in_per) begin
            if (s_r.mode == pin_meas_pkg::M_NPER_TIME || s_r.mode == pin_meas_pkg::M_MIN_TIME) begin
              acc_p = sat_inc(s_r.acc);
            end else if (s_r.a_s2) begin
              acc_p = sat_inc(s_r.acc);
            end
            if (b_ev) begin
              per_end = 1'b1;
              hits_p = sat_inc(s_r.hits);
            end
          end
          s_nxt.cnt = sat_inc(s_r.cnt);
          s_nxt.acc = acc_p;
          s_nxt.hits = hits_p;
          if (per_end) begin
            s_nxt.in_per = a_ev;
          end else if (!s_r.in_per && a_ev) begin
            s_nxt.in_per = 1'b1;
          end
          if (s_r.mode <= pin_meas_pkg::M_NPER_STATES) begin
            fin = per_end && (hits_p >= s_r.period_x);
          end else begin
            fin = per_end && (sat_inc(s_r.cnt) >= s_r.period_x);
          end
          if (fin) begin
            s_nxt.result = (s_r.mode == pin_meas_pkg::M_MIN_PERIODS) ? hits_p : acc_p;
            s_nxt.acc = 32'h00000000;
            s_nxt.hits = 32'h00000000;
            s_nxt.cnt = 32'h00000000;
            done = 1'b1;
          end
        end
        default: s_nxt.acc = s_r.acc;
      endcase
    end

    // completion flag: set wins over clear
    if (!s_r.run) begin
      s_nxt.flag = 1'b0;
    end else if (done) begin
      s_nxt.flag = 1'b1;
    end else if (clear) begin
      s_nxt.flag = 1'b0;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= pin_meas_pkg::ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata = s_r.rdata;
  assign waitrequest = s_r.waitreq;
  assign done_flag = s_r.flag;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence seq_req_seen;
    (read || write) && s_r.waitreq;
  endsequence

  sequence seq_answer;
    !s_r.waitreq ##1 s_r.waitreq;
  endsequence

  chk_bus_answer: assert property (seq_req_seen |=> seq_answer)
    else $error("bus request not answered in one cycle");

  chk_reset_flag_low: assert property (!s_r.run |=> !s_r.flag)
    else $error("flag high while held in reset");

  chk_count_reset_z: assert property (!s_r.run && is_count && $stable(s_r.mode) |=> s_r.result == $past(inc))
    else $error("count reset result not adder value");

  chk_timing_reset_one: assert property (!s_r.run && (s_r.mode == pin_meas_pkg::M_TIME_STATE ||
      s_r.mode == pin_meas_pkg::M_TIME_HIGH || s_r.mode == pin_meas_pkg::M_TIME_XHIGHS)
      |=> s_r.result == pin_meas_pkg::TIMING_RESET_RESULT)
    else $error("timing reset result not one");

  chk_period_reset_zero: assert property (!s_r.run && s_r.mode >= pin_meas_pkg::M_NPER_TIME &&
      s_r.mode <= pin_meas_pkg::M_MIN_PERIODS |=> s_r.result == pin_meas_pkg::PERIOD_RESET_RESULT)
    else $error("period reset result not zero");

  chk_total_runs: assert property (s_r.run && s_r.mode == pin_meas_pkg::M_CNT_HIGH &&
      s_r.period_x == 32'h00000000 |=> s_r.acc == $past(s_r.acc) + {31'h00000000, $past(s_r.a_s2)} &&
      s_r.result == s_r.acc)
    else $error("totalizer did not follow A highs");

  chk_period_wrap: assert property (s_r.run && is_count && s_r.period_x != 32'h00000000 &&
      s_r.cnt == s_r.period_x - 32'h00000001 |=> s_r.flag && s_r.acc == $past(inc) &&
      s_r.result == $past(s_r.acc))
    else $error("periodic count did not latch");

  chk_state_latch: assert property (s_r.run && s_r.mode == pin_meas_pkg::M_TIME_STATE &&
      s_r.a_s2 != s_r.a_prev |=> s_r.flag && s_r.cflag == $past(s_r.a_prev) && s_r.result == $past(s_r.acc))
    else $error("state change not latched");

  chk_result_sat: assert property (s_r.run && is_timing && done |=> s_r.result <= pin_meas_pkg::RESULT_MAX)
    else $error("timing result above limit");

  chk_flag_holds: assert property (s_r.flag && s_r.run && !clear |=> s_r.flag [*1])
    else $error("flag dropped without acknowledge");

endmodule

// [pin_meas_pkg.sv]
// package: register map, mode codes and state record of the pin measurement unit
// assumes: a 32-bit avalon-mm slave port and one 200 MHz system clock
package pin_meas_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MODE = 5'h04;
  localparam logic [4:0] OFF_PERIOD = 5'h08;
  localparam logic [4:0] OFF_EDGE = 5'h0c;
  localparam logic [4:0] OFF_RESULT_ACK = 5'h10;
  localparam logic [4:0] OFF_RESULT_QUIET = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam logic [4:0] OFF_ACK = 5'h1c;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int MODE_B_SAME_BIT = 8;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_CFLAG_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int EDGE_A_ANY_BIT = 1;
  localparam int EDGE_B_ANY_BIT = 0;

  // ************************************************************
  // mode codes
  // ************************************************************
  localparam logic [4:0] M_CNT_HIGH = 5'h0c;
  localparam logic [4:0] M_CNT_EDGE = 5'h0d;
  localparam logic [4:0] M_CMP_HIGH = 5'h0e;
  localparam logic [4:0] M_CMP_EDGE = 5'h0f;
  localparam logic [4:0] M_TIME_STATE = 5'h10;
  localparam logic [4:0] M_TIME_HIGH = 5'h11;
  localparam logic [4:0] M_TIME_XHIGHS = 5'h12;
  localparam logic [4:0] M_NPER_TIME = 5'h13;
  localparam logic [4:0] M_NPER_STATES = 5'h14;
  localparam logic [4:0] M_MIN_TIME = 5'h15;
  localparam logic [4:0] M_MIN_STATES = 5'h16;
  localparam logic [4:0] M_MIN_PERIODS = 5'h17;

  // ************************************************************
  // values
  // ************************************************************
  localparam logic [31:0] RESULT_MAX = 32'h80000000;
  localparam logic [31:0] TIMING_RESET_RESULT = 32'h00000001;
  localparam logic [31:0] PERIOD_RESET_RESULT = 32'h00000000;

  // ************************************************************
  // state record
  // ************************************************************
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic run;
    logic [4:0] mode;
    logic b_same;
    logic [31:0] period_x;
    logic [1:0] edge_y;
    logic a_s1;
    logic a_s2;
    logic a_prev;
    logic b_s1;
    logic b_s2;
    logic b_prev;
    logic [31:0] acc;
    logic [31:0] cnt;
    logic [31:0] hits;
    logic in_per;
    logic [31:0] result;
    logic flag;
    logic cflag;
  } meas_state_t;

  localparam meas_state_t ST_RESET = '{waitreq: 1'b1, default: '0};

endpackage

// [pin_src.sv]
// partner: drives the two measured pins, as plain levels or as a square wave on pin a
// assumes: the bench changes its controls right after a rising ref_clk edge
`timescale 1ns/10ps

module pin_src (
  input wire logic ref_clk,
  input wire logic sq_en,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] per_len,
  input wire logic lvl_a,
  input wire logic lvl_b,
  output logic pin_a,
  output logic pin_b
);
  // ****************************************
  // pin drivers
  // ****************************************
  logic [7:0] ph_r;

  always_ff @(posedge ref_clk) begin
    ph_r <= (!sq_en || ph_r + 8'h01 >= per_len) ? 8'h00 : ph_r + 8'h01;
    pin_a <= sq_en ? (ph_r < hi_len) : lvl_a;
    pin_b <= lvl_b;
  end
endmodule

// [tb.sv]
// tb: self-checking bench for the pin measurement unit
// assumes: pin_meas_pkg, pin_meas and pin_src are compiled first
`timescale 1ns/10ps

module tb;
  logic ref_clk, rst, read, write, waitrequest, pin_a, pin_b, done_flag;
  logic sq_en, lvl_a, lvl_b;
  logic [4:0] address;
  logic [31:0] writedata, readdata, tmp;
  logic [7:0] hi_len, per_len;
  logic [31:0] exp_q[$], msk_q[$];
  string nm_q[$];
  int error_cnt, n_compared, cyc, k1, k2;
  logic [4:0] tm[9] = '{5'h13, 5'h13, 5'h13, 5'h13, 5'h14, 5'h14, 5'h15, 5'h16, 5'h17};
  logic [1:0] ty[9] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0, 2'h0, 2'h0};
  logic [31:0] te[9] = '{32'h10, 32'h6, 32'h10, 32'h8, 32'h6, 32'h3, 32'h18, 32'h9, 32'h3};

  pin_meas pin_meas_i (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pin_a(pin_a), .pin_b(pin_b),
    .done_flag(done_flag));
  pin_src pin_src_i (.ref_clk(ref_clk), .sq_en(sq_en), .hi_len(hi_len), .per_len(per_len),
    .lvl_a(lvl_a), .lvl_b(lvl_b), .pin_a(pin_a), .pin_b(pin_b));

  // ****************************************
  // clock, checks, verdict
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
      if (address == pin_meas_pkg::OFF_STATUS && msk_q[0][0] === 1'b1) begin
        check("done pin", {31'h0, done_flag}, {31'h0, exp_q[0][0]});
      end
      check(nm_q.pop_front(), readdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error timeout expected finish seen hang");
      give_verdict();
    end
  end

  // ****************************************
  // bus and pin tasks
  // ****************************************
  task automatic bus(input logic rd_n, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= rd_n;
    write <= !rd_n;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 32'h0);
  endtask

  task automatic cfg(input logic [4:0] md, input logic [31:0] x, input logic [1:0] y, input logic same,
                     input logic go);
    wr(pin_meas_pkg::OFF_CTRL, 32'h0);
    wr(pin_meas_pkg::OFF_MODE, {23'h0, same, 3'h0, md});
    wr(pin_meas_pkg::OFF_PERIOD, x);
    wr(pin_meas_pkg::OFF_EDGE, {30'h0, y});
    if (go) wr(pin_meas_pkg::OFF_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse(input logic on_b, input int k);
    @(posedge ref_clk);
    if (on_b) lvl_b <= 1'b1;
    else lvl_a <= 1'b1;
    repeat (k) @(posedge ref_clk);
    lvl_a <= 1'b0;
    lvl_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic wait_flag();
    @(posedge ref_clk);
    while (done_flag !== 1'b1) @(posedge ref_clk);
  endtask

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    sq_en = 1'b0;
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    hi_len = 8'h03;
    per_len = 8'h08;
    void'($urandom(32'haa0f56d3));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd("status after reset", pin_meas_pkg::OFF_STATUS, 32'h0, 32'hffffffff);
    rd("unmapped", 5'h02, 32'h0, 32'hffffffff);
    for (int md = 'h0c; md < 'h18; md++) begin
      cfg(md[4:0], 32'h0, 2'h0, 1'b0, 1'b0);
      tmp = (md >= 'h10 && md < 'h13) ? 32'h1 : 32'h0;
      rd("held result", pin_meas_pkg::OFF_RESULT_QUIET, tmp, 32'hffffffff);
      rd("held flag", pin_meas_pkg::OFF_STATUS, 32'h0, 32'h5);
    end
    lvl_a <= 1'b1;
    cfg(pin_meas_pkg::M_CNT_HIGH, 32'h0, 2'h0, 1'b0, 1'b0);
    rd("held adder plus", pin_meas_pkg::OFF_RESULT_QUIET, 32'h1, 32'hffffffff);
    lvl_a <= 1'b0;
    lvl_b <= 1'b1;
    cfg(pin_meas_pkg::M_CMP_HIGH, 32'h0, 2'h0, 1'b0, 1'b0);
    rd("held adder minus", pin_meas_pkg::OFF_RESULT_QUIET, 32'hffffffff, 32'hffffffff);
    lvl_b <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      k1 = 3 + $urandom % 12;
      k2 = 3 + $urandom % 12;
      cfg(pin_meas_pkg::M_CNT_HIGH + i[4:0], 32'h0, 2'h0, 1'b0, 1'b1);
      if (i[0]) begin
        repeat (k1) pulse(1'b0, 2);
        repeat (k2) pulse(1'b1, 2);
      end else begin
        pulse(1'b0, k1);
        pulse(1'b1, k2);
      end
      repeat (4) @(posedge ref_clk);
      tmp = (i >= 2) ? k1 - k2 : k1;
      rd("total", pin_meas_pkg::OFF_RESULT_QUIET, tmp, 32'hffffffff);
    end
    lvl_a <= 1'b1;
    cfg(pin_meas_pkg::M_CNT_HIGH, 32'h28, 2'h0, 1'b0, 1'b1);
    wait_flag();
    wr(pin_meas_pkg::OFF_ACK, 32'h0);
    rd("flag acked", pin_meas_pkg::OFF_STATUS, 32'h4, 32'h5);
    wait_flag();
    rd("period count", pin_meas_pkg::OFF_RESULT_QUIET, 32'h28, 32'hffffffff);
    rd("flag held", pin_meas_pkg::OFF_STATUS, 32'h5, 32'h5);
    rd("period count ack", pin_meas_pkg::OFF_RESULT_ACK, 32'h28, 32'hffffffff);
    rd("flag read acked", pin_meas_pkg::OFF_STATUS, 32'h4, 32'h5);
    wait_flag();
    wr(pin_meas_pkg::OFF_PERIOD, 32'h28);
    rd("flag config cleared", pin_meas_pkg::OFF_STATUS, 32'h4, 32'h5);
    cfg(pin_meas_pkg::M_TIME_XHIGHS, 32'h5, 2'h0, 1'b0, 1'b1);
    wait_flag();
    rd("timed highs", pin_meas_pkg::OFF_RESULT_QUIET, 32'h5, 32'hffffffff);
    lvl_a <= 1'b0;
    k1 = 4 + $urandom % 20;
    k2 = 4 + $urandom % 20;
    cfg(pin_meas_pkg::M_TIME_STATE, 32'h0, 2'h0, 1'b0, 1'b1);
    pulse(1'b0, k1);
    repeat (k2 - 3) @(posedge ref_clk);
    lvl_a <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd("state time", pin_meas_pkg::OFF_RESULT_QUIET, k2, 32'hffffffff);
    rd("state flag", pin_meas_pkg::OFF_STATUS, 32'h5, 32'h7);
    lvl_a <= 1'b0;
    cfg(pin_meas_pkg::M_TIME_HIGH, 32'h0, 2'h0, 1'b0, 1'b1);
    pulse(1'b0, k1);
    repeat (3) @(posedge ref_clk);
    rd("high time", pin_meas_pkg::OFF_RESULT_QUIET, k1, 32'hffffffff);
    rd("high flag", pin_meas_pkg::OFF_STATUS, 32'h1, 32'h1);
    sq_en <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      cfg(tm[i], (tm[i] > 5'h14) ? 32'h14 : 32'h2, ty[i], 1'b1, 1'b1);
      wait_flag();
      wr(pin_meas_pkg::OFF_ACK, 32'h0);
      wait_flag();
      rd("period", pin_meas_pkg::OFF_RESULT_ACK, te[i], 32'hffffffff);
    end
    sq_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule
